// *** logic/csr_map.svh ***
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ==========================================================
// Data-memory addresses of the special registers
`define CSR_ADR_IND0    8'h00
`define CSR_ADR_PTR0    8'h01
`define CSR_ADR_IND1    8'h02
`define CSR_ADR_PTR1    8'h03
`define CSR_ADR_BANK    8'h04
`define CSR_ADR_HOLD    8'h05
`define CSR_ADR_PCLO    8'h06
`define CSR_ADR_TBLO    8'h07
`define CSR_ADR_TBHB    8'h08
`define CSR_ADR_TBHI    8'h09
`define CSR_ADR_STAT    8'h0A
`define CSR_SPECIAL_TOP 8'h1F
`define CSR_DM_WORDS    512
`define CSR_PM_W        16

// ==========================================================
// Status byte fields and reset values
`define CSR_FL_CARRY    0
`define CSR_FL_NIB      1
`define CSR_FL_ZERO     2
`define CSR_FL_WRAP     3
`define CSR_FL_RST      4'h0
`define CSR_UNUSED_HI   2'h0

// ==========================================================
// Bus register offsets, responses and event bits
`define CSR_AX_FLAGS    8'h00
`define CSR_AX_VIEW     8'h04
`define CSR_AX_CTRL     8'h08
`define CSR_AX_IST      8'h0C
`define CSR_AX_IMASK    8'h10
`define CSR_RESP_OKAY   2'h0
`define CSR_RESP_SLVERR 2'h2
`define CSR_EV_WDOG     0
`define CSR_EV_HALT     1
`define CSR_EV_JUMP     2
`define CSR_EV_TAB      3
`define CSR_CTRL_RST    1'h1

`endif

// *** logic/csr_pkg.sv ***
`default_nettype none

package csr_pkg;

    // ======================================================
    // Commands from the execution unit
    typedef enum logic [2:0] {
        OP_NOP,
        OP_READ,
        OP_WRITE,
        OP_ALU,
        OP_TABRD,
        OP_HALT,
        OP_KICK
    } csr_op_e;

    typedef enum logic [3:0] {
        ALU_ADD,
        ALU_ADC,
        ALU_SUB,
        ALU_SBC,
        ALU_AND,
        ALU_OR,
        ALU_XOR,
        ALU_RLC,
        ALU_RRC
    } csr_alu_e;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_DUMMY,
        ST_TABLE
    } csr_state_e;

    typedef struct packed {
        logic       valid;
        csr_op_e    op;
        csr_alu_e   alu;
        logic       use_imm;
        logic [7:0] addr;
        logic [7:0] imm;
    } csr_exec_s;

    // ======================================================
    // AXI4-Lite channels
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } csr_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } csr_axi_rsp_s;

    typedef struct packed {
        csr_state_e   state;
        logic [7:0]   hold;
        logic [7:0]   ptr0;
        logic [7:0]   ptr1;
        logic         bank;
        logic [7:0]   program_counter_low_byte;
        logic [7:0]   tblo;
        logic [7:0]   tbhi;
        logic [7:0]   tbhb;
        logic [7:0]   tdest;
        logic [3:0]   fl;
        logic         wdog;
        logic         sleep;
        logic         busy;
        logic         jump;
        logic         pm_rd;
        logic         en;
        logic [3:0]   ist;
        logic [3:0]   imask;
        logic         irq;
        csr_axi_rsp_s ax;
    } csr_state_s;

endpackage

`default_nettype wire

// *** logic/csr_core.sv ***
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "csr_map.svh"

// ==========================================================
// What this block does
// [RULE1] Indirect port accesses go to the address held in the paired pointer.
// [RULE2] Port 0 reaches bank 0 only; port 1 reaches any bank.
// [RULE3] Indirect reads of a port return zero; port writes store nothing.
// [RULE4] Each pointer is a real 8-bit register, readable and writable.
// [RULE5] ALU results land in the holder; moves pass through the holder.
// [RULE6] Writing the PC low byte jumps in page and adds one dummy cycle.
// [RULE7] Table read fetches word at pointers; high byte kept, low stored.
// [RULE8] Status writes never change watchdog-expired or sleep-entered flags.
// [RULE9] Watchdog flag bit 5: set by timeout, cleared by reset, kick, halt.
// [RULE10] Sleep flag bit 4: set by halt, cleared by reset or kick.
// [RULE11] Carry bit 0: add carry out, subtract no borrow, rotates.
// [RULE12] Nibble carry bit 1: carry out of low nibble, or no borrow.
// [RULE13] Zero bit 2 set when an arithmetic or logic result is zero.
// [RULE14] Sign-wrap bit 3 set when carry into and out of bit 7 differ.
// [RULE15] Software saves the status byte itself around calls and interrupts.
// [RULE16] Status bits 7 and 6 always read as zero.
// [RULE17] The four arithmetic flags are readable and writable by software.
// [RULE18] Operations without a result leave the arithmetic flags unchanged.

module csr_core (
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_i,
    input  wire csr_pkg::csr_exec_s    exec_i,
    input  wire logic                  wdt_timeout_i,
    input  wire logic [`CSR_PM_W-1:0]  pm_data_i,
    input  wire logic                  pm_valid_i,
    input  wire csr_pkg::csr_axi_req_s axi_i,
    output var  csr_pkg::csr_axi_rsp_s axi_o,
    output var  logic [7:0]            alu_result_holder_o,
    output var  logic [7:0]            status_o,
    output var  logic [7:0]            program_counter_low_byte_o,
    output var  logic                  pc_jump_o,
    output var  logic                  busy_o,
    output var  logic                  pm_rd_o,
    output var  logic [`CSR_PM_W-1:0]  pm_addr_o,
    output var  logic                  irq_o
);

    csr_pkg::csr_state_s st_ff;
    csr_pkg::csr_state_s nxt_st;
    logic [7:0]          dm_mem [0:`CSR_DM_WORDS-1];
    logic                mem_we;
    logic [8:0]          mem_wa;
    logic [7:0]          mem_wd;
    logic                take;
    logic                tab_done;

    // ======================================================
    // Address resolution
    // Special registers repeat in every bank, so the bank bit
    // only matters for the general area.
    function automatic logic [8:0] eff_adr(
        input logic [7:0]          a,
        input csr_pkg::csr_state_s s
    );
        if (a == `CSR_ADR_IND0) begin
            eff_adr = {1'b0, s.ptr0}; // [RULE1] [RULE2]
        end else if (a == `CSR_ADR_IND1) begin
            eff_adr = {s.bank, s.ptr1}; // [RULE1] [RULE2]
        end else begin
            eff_adr = {1'b0, a};
        end
    endfunction

    function automatic logic [7:0] rd_byte(
        input logic [8:0]          ea,
        input csr_pkg::csr_state_s s
    );
        rd_byte = 8'h00;
        if (ea[7:0] > `CSR_SPECIAL_TOP) begin
            rd_byte = dm_mem[ea];
        end else begin
            case (ea[7:0])
                `CSR_ADR_PTR0: rd_byte = s.ptr0; // [RULE4]
                `CSR_ADR_PTR1: rd_byte = s.ptr1; // [RULE4]
                `CSR_ADR_BANK: rd_byte = {7'h00, s.bank};
                `CSR_ADR_HOLD: rd_byte = s.hold;
                `CSR_ADR_PCLO: rd_byte = s.program_counter_low_byte;
                `CSR_ADR_TBLO: rd_byte = s.tblo;
                `CSR_ADR_TBHI: rd_byte = s.tbhi;
                `CSR_ADR_TBHB: rd_byte = s.tbhb;
                `CSR_ADR_STAT: begin
                    rd_byte = {`CSR_UNUSED_HI, s.wdog, s.sleep, s.fl}; // [RULE16]
                end
                // Port addresses and unused slots read as zero.
                default: rd_byte = 8'h00; // [RULE3]
            endcase
        end
    endfunction

    // ======================================================
    // Next-state logic
    always_comb begin
        logic [8:0]  ea;
        logic [7:0]  opnd;
        logic [7:0]  b2;
        logic [7:0]  res;
        logic        ci;
        logic        rot_c;
        logic        arith;
        logic        logic_op;
        logic        rot;
        logic [4:0]  lo;
        logic [7:0]  mid;
        logic [8:0]  sum;
        logic        wr;
        logic [8:0]  wr_ea;
        logic [7:0]  wr_dat;
        logic [3:0]  ev;
        logic [3:0]  clr;
        logic [31:0] rdat;
        ea       = 9'h000;
        opnd     = 8'h00;
        b2       = 8'h00;
        res      = 8'h00;
        ci       = 1'b0;
        rot_c    = 1'b0;
        arith    = 1'b0;
        logic_op = 1'b0;
        rot      = 1'b0;
        lo       = 5'h00;
        mid      = 8'h00;
        sum      = 9'h000;
        wr       = 1'b0;
        wr_ea    = 9'h000;
        wr_dat   = 8'h00;
        ev       = 4'h0;
        clr      = 4'h0;
        rdat     = 32'h0000_0000;
        nxt_st       = st_ff;
        nxt_st.jump  = 1'b0;
        nxt_st.pm_rd = 1'b0;
        mem_we   = 1'b0;
        mem_wa   = 9'h000;
        mem_wd   = 8'h00;
        tab_done = 1'b0;
        take = exec_i.valid && st_ff.en
            && (st_ff.state == csr_pkg::ST_RUN);

        ea   = eff_adr(exec_i.addr, st_ff);
        opnd = exec_i.use_imm ? exec_i.imm : rd_byte(ea, st_ff);

        // A single adder serves both add and subtract; subtract
        // uses the inverted operand so carry means no borrow.
        arith = (exec_i.alu == csr_pkg::ALU_ADD)
            || (exec_i.alu == csr_pkg::ALU_ADC)
            || (exec_i.alu == csr_pkg::ALU_SUB)
            || (exec_i.alu == csr_pkg::ALU_SBC);
        logic_op = (exec_i.alu == csr_pkg::ALU_AND)
            || (exec_i.alu == csr_pkg::ALU_OR)
            || (exec_i.alu == csr_pkg::ALU_XOR);
        rot = (exec_i.alu == csr_pkg::ALU_RLC)
            || (exec_i.alu == csr_pkg::ALU_RRC);
        b2 = ((exec_i.alu == csr_pkg::ALU_SUB)
            || (exec_i.alu == csr_pkg::ALU_SBC)) ? ~opnd : opnd;
        if (exec_i.alu == csr_pkg::ALU_ADD) begin
            ci = 1'b0;
        end else if (exec_i.alu == csr_pkg::ALU_SUB) begin
            ci = 1'b1;
        end else begin
            ci = st_ff.fl[`CSR_FL_CARRY];
        end
        lo  = 5'(st_ff.hold[3:0]) + 5'(b2[3:0]) + 5'(ci);
        mid = 8'(st_ff.hold[6:0]) + 8'(b2[6:0]) + 8'(ci);
        sum = 9'(st_ff.hold) + 9'(b2) + 9'(ci);

        unique case (exec_i.alu)
            csr_pkg::ALU_ADD,
            csr_pkg::ALU_ADC,
            csr_pkg::ALU_SUB,
            csr_pkg::ALU_SBC: res = sum[7:0];
            csr_pkg::ALU_AND: res = st_ff.hold & opnd;
            csr_pkg::ALU_OR:  res = st_ff.hold | opnd;
            csr_pkg::ALU_XOR: res = st_ff.hold ^ opnd;
            csr_pkg::ALU_RLC: begin
                res   = {st_ff.hold[6:0], st_ff.fl[`CSR_FL_CARRY]};
                rot_c = st_ff.hold[7];
            end
            csr_pkg::ALU_RRC: begin
                res   = {st_ff.fl[`CSR_FL_CARRY], st_ff.hold[7:1]};
                rot_c = st_ff.hold[0];
            end
            default: res = st_ff.hold;
        endcase

        // ----- instruction execution -----
        if (take) begin
            case (exec_i.op)
                csr_pkg::OP_READ: begin
                    nxt_st.hold = opnd; // [RULE5]
                end
                csr_pkg::OP_WRITE: begin
                    // Stores always come from the holder. // [RULE5]
                    wr     = 1'b1;
                    wr_ea  = ea;
                    wr_dat = st_ff.hold;
                end
                csr_pkg::OP_ALU: begin
                    nxt_st.hold = res; // [RULE5]
                    if (arith) begin // [RULE18]
                        nxt_st.fl[`CSR_FL_CARRY] = sum[8]; // [RULE11]
                        nxt_st.fl[`CSR_FL_NIB]   = lo[4]; // [RULE12]
                        nxt_st.fl[`CSR_FL_WRAP]  = mid[7] ^ sum[8]; // [RULE14]
                    end
                    if (arith || logic_op) begin
                        nxt_st.fl[`CSR_FL_ZERO] = (res == 8'h00); // [RULE13]
                    end
                    if (rot) begin
                        nxt_st.fl[`CSR_FL_CARRY] = rot_c; // [RULE11]
                    end
                end
                csr_pkg::OP_TABRD: begin
                    nxt_st.state = csr_pkg::ST_TABLE; // [RULE7]
                    nxt_st.busy  = 1'b1;
                    nxt_st.pm_rd = 1'b1;
                    nxt_st.tdest = exec_i.addr;
                end
                csr_pkg::OP_HALT: begin
                    nxt_st.sleep = 1'b1; // [RULE10]
                    nxt_st.wdog  = 1'b0; // [RULE9]
                    ev[`CSR_EV_HALT] = 1'b1;
                end
                csr_pkg::OP_KICK: begin
                    nxt_st.sleep = 1'b0; // [RULE10]
                    nxt_st.wdog  = 1'b0; // [RULE9]
                end
                default: begin
                end
            endcase
        end

        // ----- sequencer -----
        if (st_ff.state == csr_pkg::ST_DUMMY) begin
            nxt_st.state = csr_pkg::ST_RUN; // [RULE6]
            nxt_st.busy  = 1'b0;
        end
        if ((st_ff.state == csr_pkg::ST_TABLE) && pm_valid_i) begin
            tab_done     = 1'b1;
            nxt_st.tbhb  = pm_data_i[15:8]; // [RULE7]
            wr           = 1'b1;
            wr_ea        = eff_adr(st_ff.tdest, st_ff);
            wr_dat       = pm_data_i[7:0]; // [RULE7]
            nxt_st.state = csr_pkg::ST_RUN;
            nxt_st.busy  = 1'b0;
            ev[`CSR_EV_TAB] = 1'b1;
        end

        // ----- data-memory write decode -----
        if (wr) begin
            if (wr_ea[7:0] > `CSR_SPECIAL_TOP) begin
                mem_we = 1'b1;
                mem_wa = wr_ea;
                mem_wd = wr_dat;
            end else begin
                case (wr_ea[7:0])
                    `CSR_ADR_PTR0: nxt_st.ptr0 = wr_dat; // [RULE4]
                    `CSR_ADR_PTR1: nxt_st.ptr1 = wr_dat; // [RULE4]
                    `CSR_ADR_BANK: nxt_st.bank = wr_dat[0];
                    `CSR_ADR_HOLD: nxt_st.hold = wr_dat;
                    `CSR_ADR_TBLO: nxt_st.tblo = wr_dat;
                    `CSR_ADR_TBHI: nxt_st.tbhi = wr_dat;
                    `CSR_ADR_TBHB: nxt_st.tbhb = wr_dat;
                    `CSR_ADR_STAT: begin
                        // Only the arithmetic flags take the data.
                        nxt_st.fl = wr_dat[3:0]; // [RULE8] [RULE17]
                    end
                    `CSR_ADR_PCLO: begin
                        nxt_st.program_counter_low_byte   = wr_dat; // [RULE6]
                        nxt_st.jump  = 1'b1;
                        nxt_st.state = csr_pkg::ST_DUMMY;
                        nxt_st.busy  = 1'b1;
                        ev[`CSR_EV_JUMP] = 1'b1;
                    end
                    default: begin
                    end // [RULE3]
                endcase
            end
        end

        // A timeout in the same cycle as a kick or halt wins.
        if (wdt_timeout_i) begin
            nxt_st.wdog = 1'b1; // [RULE9]
            ev[`CSR_EV_WDOG] = 1'b1;
        end

        // ----- AXI4-Lite write channel -----
        if (st_ff.ax.bvalid && axi_i.bready) begin
            nxt_st.ax.bvalid = 1'b0;
        end
        if (st_ff.ax.awready) begin
            nxt_st.ax.awready = 1'b0;
            nxt_st.ax.wready  = 1'b0;
            if (axi_i.awvalid && axi_i.wvalid) begin
                nxt_st.ax.bvalid = 1'b1;
                nxt_st.ax.bresp  = `CSR_RESP_OKAY;
                case (axi_i.awaddr)
                    `CSR_AX_CTRL: begin
                        if (axi_i.wstrb[0]) begin
                            nxt_st.en = axi_i.wdata[0];
                        end
                    end
                    `CSR_AX_IST: begin
                        if (axi_i.wstrb[0]) begin
                            clr = axi_i.wdata[3:0];
                        end
                    end
                    `CSR_AX_IMASK: begin
                        if (axi_i.wstrb[0]) begin
                            nxt_st.imask = axi_i.wdata[3:0];
                        end
                    end
                    `CSR_AX_FLAGS,
                    `CSR_AX_VIEW: begin
                    end
                    default: nxt_st.ax.bresp = `CSR_RESP_SLVERR;
                endcase
            end
        end else if (axi_i.awvalid && axi_i.wvalid
                && !st_ff.ax.bvalid) begin
            nxt_st.ax.awready = 1'b1;
            nxt_st.ax.wready  = 1'b1;
        end

        // Event bits are sticky; a new event beats a clear.
        nxt_st.ist = (st_ff.ist & ~clr) | ev;
        nxt_st.irq = |(nxt_st.ist & nxt_st.imask);

        // ----- AXI4-Lite read channel -----
        if (st_ff.ax.rvalid && axi_i.rready) begin
            nxt_st.ax.rvalid = 1'b0;
        end
        if (st_ff.ax.arready) begin
            nxt_st.ax.arready = 1'b0;
            if (axi_i.arvalid) begin
                nxt_st.ax.rvalid = 1'b1;
                nxt_st.ax.rresp  = `CSR_RESP_OKAY;
                case (axi_i.araddr)
                    `CSR_AX_FLAGS: begin
                        rdat = {24'h00_0000, `CSR_UNUSED_HI,
                            st_ff.wdog, st_ff.sleep, st_ff.fl};
                    end
                    `CSR_AX_VIEW: begin
                        rdat = {st_ff.ptr1, st_ff.ptr0,
                            st_ff.program_counter_low_byte, st_ff.hold};
                    end
                    `CSR_AX_CTRL:  rdat = {31'h0, st_ff.en};
                    `CSR_AX_IST:   rdat = {28'h000_0000, st_ff.ist};
                    `CSR_AX_IMASK: rdat = {28'h000_0000, st_ff.imask};
                    default: nxt_st.ax.rresp = `CSR_RESP_SLVERR;
                endcase
                nxt_st.ax.rdata = rdat;
            end
        end else if (axi_i.arvalid && !st_ff.ax.rvalid) begin
            nxt_st.ax.arready = 1'b1;
        end
    end

    // ======================================================
    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff    <= '0;
            st_ff.fl <= `CSR_FL_RST;
            st_ff.en <= `CSR_CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Plain RAM without reset; contents are undefined at power-up.
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            dm_mem[mem_wa] <= mem_wd;
        end
    end

    assign axi_o                      = st_ff.ax;
    assign alu_result_holder_o        = st_ff.hold;
    assign status_o = {`CSR_UNUSED_HI, st_ff.wdog, st_ff.sleep, st_ff.fl};
    assign program_counter_low_byte_o = st_ff.program_counter_low_byte;
    assign pc_jump_o                  = st_ff.jump;
    assign busy_o                     = st_ff.busy;
    assign pm_rd_o                    = st_ff.pm_rd;
    assign pm_addr_o                  = {st_ff.tbhi, st_ff.tblo};
    assign irq_o                      = st_ff.irq;

    // ======================================================
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    logic [8:0] chk_sum_ff;
    always_ff @(posedge ref_clk_i) begin
        chk_sum_ff <= 9'(st_ff.hold) + 9'(exec_i.imm);
    end

    sequence s_pcl_write;
        take && (exec_i.op == csr_pkg::OP_WRITE)
            && (exec_i.addr == `CSR_ADR_PCLO);
    endsequence

    sequence s_dummy_slot;
        (pc_jump_o && busy_o) ##1 (!busy_o && !pc_jump_o);
    endsequence

    a_pcl_dummy_slot: assert property ( // [RULE6]
        s_pcl_write |=> s_dummy_slot)
        else $error("PC low write did not add one dummy cycle.");

    a_status_upper_zero: assert property ( // [RULE16]
        status_o[7:6] == 2'b00)
        else $error("Status bits 7 and 6 are not zero.");

    a_wdog_timeout_set: assert property ( // [RULE9]
        wdt_timeout_i |=> status_o[5])
        else $error("Watchdog timeout did not set the flag.");

    a_halt_flags: assert property ( // [RULE10]
        take && (exec_i.op == csr_pkg::OP_HALT) && !wdt_timeout_i
        |=> status_o[5:4] == 2'b01)
        else $error("Halt did not set sleep and clear watchdog.");

    a_kick_flags: assert property ( // [RULE10]
        take && (exec_i.op == csr_pkg::OP_KICK) && !wdt_timeout_i
        |=> status_o[5:4] == 2'b00)
        else $error("Kick did not clear both system flags.");

    a_status_write_keep: assert property ( // [RULE8]
        take && (exec_i.op == csr_pkg::OP_WRITE)
        && (exec_i.addr == `CSR_ADR_STAT) && !wdt_timeout_i
        |=> ((status_o & 8'h30) == ($past(status_o) & 8'h30))
        && (status_o[3:0] == alu_result_holder_o[3:0]))
        else $error("Status write disturbed the system flags.");

    a_flags_stable: assert property ( // [RULE18]
        !take && !tab_done |=> $stable(status_o[3:0]))
        else $error("Arithmetic flags changed without a result.");

    a_zero_flag: assert property ( // [RULE13]
        take && (exec_i.op == csr_pkg::OP_ALU)
        && (exec_i.alu <= csr_pkg::ALU_XOR)
        |=> status_o[2] == (alu_result_holder_o == 8'h00))
        else $error("Zero flag does not match the result.");

    a_add_carry: assert property ( // [RULE11]
        take && (exec_i.op == csr_pkg::OP_ALU)
        && (exec_i.alu == csr_pkg::ALU_ADD) && exec_i.use_imm
        |=> (status_o[0] == chk_sum_ff[8])
        && (alu_result_holder_o == chk_sum_ff[7:0]))
        else $error("Add result or carry is wrong.");

    a_table_fetch: assert property ( // [RULE7]
        take && (exec_i.op == csr_pkg::OP_TABRD)
        |=> pm_rd_o && busy_o ##1 !pm_rd_o)
        else $error("Table read did not issue one fetch.");

endmodule // csr_core

`default_nettype wire

// *** verification/csr_pm_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============================================
// Program memory seen by the table fetch.
module csr_pm_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        slow_i,
    output var  logic [15:0] data_o,
    output var  logic        valid_o
);
    int cnt = -1;
    initial data_o = 16'h0000;
    initial valid_o = 1'b0;
    // Data flips every cycle outside the answer so no stale word passes.
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
        if (rd_i) cnt <= slow_i ? 5 : 0;
        else if (cnt > 0) cnt <= cnt - 1;
        else if (cnt == 0) begin
            valid_o <= 1'b1;
            data_o <= {~addr_i[7:0], addr_i[15:8]};
            cnt <= -1;
        end
    end
endmodule // csr_pm_model
`default_nettype wire

// *** verification/cpu_special_registers_status_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "csr_map.svh"
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin \
miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cpu_special_registers_status_tb;
    localparam csr_pkg::csr_op_e RD = csr_pkg::OP_READ;
    localparam csr_pkg::csr_op_e WR = csr_pkg::OP_WRITE;
    logic c, r, wdt, slow, pmv, bsy, irq, pmr;
    logic [15:0] pmd, pma;
    logic [7:0] hd, st, rnd, program_counter_low_byte;
    logic [33:0] e;
    logic [33:0] q[$];
    csr_pkg::csr_exec_s ex;
    csr_pkg::csr_axi_req_s rq;
    csr_pkg::csr_axi_rsp_s rs;
    int miscompares = 0;
    int check_count = 0;
    csr_core u_dut (.ref_clk_i(c), .reset_i(r), .exec_i(ex),
        .wdt_timeout_i(wdt), .pm_data_i(pmd), .pm_valid_i(pmv),
        .axi_i(rq), .axi_o(rs), .alu_result_holder_o(hd), .status_o(st),
        .program_counter_low_byte_o(program_counter_low_byte), .pc_jump_o(), .busy_o(bsy),
        .pm_rd_o(pmr), .pm_addr_o(pma), .irq_o(irq));
    csr_pm_model u_pm (.clk_i(c), .rd_i(pmr), .addr_i(pma),
        .slow_i(slow), .data_o(pmd), .valid_o(pmv));
    initial begin c = 1'b0; forever #5 c = ~c; end
    task tally_and_finish;
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #50us; miscompares++; tally_and_finish; end
    // ============================================
    // Read answers are matched in order against the noted expectations.
    always @(posedge c) if (rs.rvalid === 1'b1 && rq.rready) begin
        e = q.pop_front();
        `CHK({rs.rresp, rs.rdata}, e)
    end
    task x(input csr_pkg::csr_op_e o, input logic [7:0] a, m, input u);
        @(posedge c) ex <= '{1'b1, o, csr_pkg::ALU_ADD, u, a, m};
        @(posedge c) ex.valid <= 1'b0;
        do @(negedge c); while (bsy !== 1'b0);
    endtask
    task ld(input logic [7:0] v); x(RD, 8'h00, v, 1'b1); endtask
    task lm(input logic [7:0] a); x(RD, a, 8'h00, 1'b0); endtask
    task sv(input logic [7:0] a); x(WR, a, 8'h00, 1'b0); endtask
    task rd(input logic [7:0] a, input logic [33:0] v);
        q.push_back(v);
        @(posedge c) rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        do @(posedge c); while (rs.arready !== 1'b1);
        rq.arvalid <= 1'b0;
        do @(posedge c); while (rs.rvalid !== 1'b1);
        rq.rready <= 1'b0;
    endtask
    task wr(input logic [7:0] a, d, input logic [1:0] v);
        @(posedge c) {rq.awvalid, rq.wvalid} <= 2'h3;
        rq.awaddr <= a;
        rq.wdata <= {24'h000000, d};
        rq.wstrb <= 4'hF;
        do @(posedge c); while (rs.awready !== 1'b1);
        {rq.awvalid, rq.wvalid} <= 2'h0;
        rq.bready <= 1'b1;
        do @(posedge c); while (rs.bvalid !== 1'b1);
        rq.bready <= 1'b0;
        `CHK(rs.bresp, v)
    endtask
    initial begin
        r = 1'b1; wdt = 1'b0; slow = 1'b0; ex = '0; rq = '0;
        rnd = 8'($urandom(31));
        repeat (2) @(posedge c);
        r <= 1'b0;
        rd(`CSR_AX_FLAGS, 34'h0);
        ld(8'h80); x(csr_pkg::OP_ALU, 8'h00, 8'h80, 1'b1);
        rd(`CSR_AX_FLAGS, 34'h0D);
        ld(8'h08); x(csr_pkg::OP_ALU, 8'h00, 8'h08, 1'b1);
        ld(8'h00); `CHK(st, 8'h02)
        ld(8'h40); sv(`CSR_ADR_PTR0); ld(rnd); sv(`CSR_ADR_IND0);
        ld(8'h00); lm(8'h40); `CHK(hd, rnd)
        ld(`CSR_ADR_IND0); sv(`CSR_ADR_PTR0);
        ld(8'hFF); lm(`CSR_ADR_IND0); `CHK(hd, 8'h00)
        ld(8'h40); sv(`CSR_ADR_PTR1); ld(8'h01); sv(`CSR_ADR_BANK);
        ld(~rnd); sv(`CSR_ADR_IND1); lm(8'h40); `CHK(hd, rnd)
        lm(`CSR_ADR_IND1); `CHK(hd, ~rnd)
        ld(8'h77); sv(`CSR_ADR_PCLO); `CHK(program_counter_low_byte, 8'h77)
        rd(`CSR_AX_VIEW, 34'h40007777);
        wr(`CSR_AX_IMASK, 8'h02, `CSR_RESP_OKAY);
        x(csr_pkg::OP_HALT, 8'h00, 8'h00, 1'b0);
        repeat (2) @(negedge c); `CHK(irq, 1'b1)
        wr(`CSR_AX_IST, 8'h02, `CSR_RESP_OKAY);
        repeat (2) @(negedge c); `CHK(irq, 1'b0)
        ld(8'hFF); sv(`CSR_ADR_STAT);
        rd(`CSR_AX_FLAGS, 34'h1F);
        x(csr_pkg::OP_KICK, 8'h00, 8'h00, 1'b0); `CHK(st, 8'h0F)
        @(posedge c) wdt <= 1'b1;
        @(posedge c) wdt <= 1'b0;
        repeat (2) @(negedge c); `CHK(st, 8'h2F)
        x(csr_pkg::OP_HALT, 8'h00, 8'h00, 1'b0); `CHK(st, 8'h1F)
        lm(`CSR_ADR_STAT); sv(8'h50); ld(8'h01);
        x(csr_pkg::OP_ALU, 8'h00, 8'hFF, 1'b1);
        `CHK(st, 8'h17)
        lm(8'h50); sv(`CSR_ADR_STAT); `CHK(st, 8'h1F)
        ld(8'h34); sv(`CSR_ADR_TBLO); ld(8'h12); sv(`CSR_ADR_TBHI);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            x(csr_pkg::OP_TABRD, 8'h41, 8'h00, 1'b0);
            lm(8'h41); `CHK(hd, 8'h12)
            lm(`CSR_ADR_TBHB); `CHK(hd, 8'hCB)
        end
        rd(8'h14, {`CSR_RESP_SLVERR, 32'h0});
        wr(8'h14, 8'h00, `CSR_RESP_SLVERR);
        `CHK(q.size(), 0)
        tally_and_finish;
    end
endmodule // cpu_special_registers_status_tb
`default_nettype wire
